// File: uss_sync_slave.sv
// Synchronous slave serial port with APB register access
// What this block does
// [R1] Shift clock always comes from the clock pin; the block never drives it.
// [R2] Slave mode is active when the clock source select bit is clear.
// [R3] Transfers keep running while the core is halted; nothing depends on halt.
// [R4] Slave transmit and receive behave like the master-mode transfers.
// [R5] A buffer write with the shifter idle loads the shifter at once.
// [R6] A word written during shifting waits in the buffer; empty flag stays low.
// [R7] After the last bit the waiting word moves on and the empty flag rises.
// [R8] Empty flag with transmit interrupt enable raises the interrupt (wake request).
// [R9] The single receive enable bit has no effect on reception.
// [R10] Continuous receive enable alone lets a word arrive, even during halt.
// [R11] A completely received word goes from the shifter into the FIFO.
// [R12] Received data with receive interrupt enable raises the interrupt.
// [R13] Receive data flag shows FIFO content; interrupt only when enabled.
// [R14] Software sets up transmit: mode bits, receive enables off, enables, then data.
// [R15] Software loads the ninth transmit bit before writing the data byte.
// [R16] Software sets up receive: mode bits, enables, then continuous receive.
// [R17] Software reads receive status before reading the received byte.
// [R18] Clearing continuous receive enable clears the error flags.
// [R19] The data pin is sampled on the falling shift-clock edge.
// [R20] FIFO holds two words; a third completing while full sets overrun, dropped.
// [R21] While overrun is set no word enters the FIFO.
// [R22] The ninth bit travels with each word; a read exposes the next entry's.
// [R23] The shift clock is synchronised and its edges found before shifting.
`timescale 1ns/1ps
`default_nettype none

`include "uss_params.svh"

module uss_sync_slave
  import uss_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`USS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   shift_clock_pin,
  input  wire logic                   serial_data_pin_i,
  output logic                        serial_data_pin_o,
  output logic                        serial_data_pin_oe,
  output logic                        irq
);

  uss_state_t r_reg;
  uss_state_t r_next;

  localparam uss_state_t ST_RST = '{transmit_status_control: `USS_TRANSMIT_STATUS_CONTROL_RST, tx_state: USS_TX_IDLE, default: '0};

  // Index of the last bit of a word for 8- or 9-bit framing
  function automatic logic [3:0] last_bit(input logic nine);
    return nine ? `USS_LAST9 : `USS_LAST8;
  endfunction : last_bit

  // Word-aligned hit on a register index
  function automatic logic reg_hit(input logic [`USS_ADDR_W-1:0] a, input logic [`USS_IDX_W-1:0] idx);
    return (a[1:0] == 2'h0) && (a[`USS_ADDR_W-1:2] == idx);
  endfunction : reg_hit

  logic clk_fall;
  logic data_lvl;
  logic slave_on;
  logic tx_on;
  logic rx_on;
  logic txf;
  logic rxf;
  logic addr_ok;
  logic acc_wr;
  logic acc_rd;
  logic pop;
  logic push;
  logic load;
  logic word_done;
  logic [7:0] rd_mux;
  logic [7:0] irqf_val;
  logic [8:0] word;

  // Clock pin is an input only; its edges come from the synchroniser
  uss_edge_sync u_clk_sync (   // [R1] [R23]
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (shift_clock_pin),
    .level    (),
    .rise     (),
    .fall     (clk_fall)
  );

  // Same latency as the clock path, so the bit sampled matches the edge seen
  uss_edge_sync u_dat_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (serial_data_pin_i),
    .level    (data_lvl),
    .rise     (),
    .fall     ()
  );

  // Mode and flag decode
  assign slave_on = r_reg.receive_status_control[`USS_B_SERIAL_PORT_ENABLE] & r_reg.transmit_status_control[`USS_B_SYNC] & ~r_reg.transmit_status_control[`USS_B_CLOCK_SOURCE_SELECT]; // [R2]
  assign tx_on    = slave_on & r_reg.transmit_status_control[`USS_B_TRANSMIT_ENABLE];
  assign rx_on    = slave_on & r_reg.receive_status_control[`USS_B_CONTINUOUS_RECEIVE_ENABLE];  // [R9] [R10]
  assign txf      = r_reg.transmit_status_control[`USS_B_TRANSMIT_ENABLE] & ~r_reg.txbuf_full; // [R6] [R7] flags read zero after reset
  assign rxf      = (r_reg.fifo_cnt != 2'h0);             // [R13]
  // No halt input exists: nothing here can stop while the core sleeps
  assign irq      = (txf & r_reg.irqe[`USS_B_TXF]) | (rxf & r_reg.irqe[`USS_B_RXF]); // [R3] [R8] [R12] [R13]

  // APB decode; zero wait states, unmapped addresses answer with an error
  always_comb begin
    addr_ok = reg_hit(paddr, `USS_IDX_IRQF) | reg_hit(paddr, `USS_IDX_RECEIVE_STATUS_CONTROL) |
              reg_hit(paddr, `USS_IDX_TXBUF) | reg_hit(paddr, `USS_IDX_RXFIFO) |
              reg_hit(paddr, `USS_IDX_IRQE) | reg_hit(paddr, `USS_IDX_TRANSMIT_STATUS_CONTROL) |
              reg_hit(paddr, `USS_IDX_BAUD);
  end
  assign pready  = penable;
  assign pslverr = psel & penable & ~addr_ok;
  assign acc_wr  = psel & penable & pwrite & addr_ok;
  assign acc_rd  = psel & penable & ~pwrite & addr_ok;
  assign prdata  = r_reg.prdata;
  assign serial_data_pin_o  = r_reg.dout;
  assign serial_data_pin_oe = r_reg.doe;

  // Read multiplexer; framing_error never sets in synchronous mode
  always_comb begin
    irqf_val = 8'h00;
    irqf_val[`USS_B_RXF] = rxf;
    irqf_val[`USS_B_TXF] = txf;
    rd_mux = 8'h00;
    if (reg_hit(paddr, `USS_IDX_IRQF)) begin
      rd_mux = irqf_val;
    end else if (reg_hit(paddr, `USS_IDX_RECEIVE_STATUS_CONTROL)) begin
      rd_mux = r_reg.receive_status_control & `USS_RECEIVE_STATUS_CONTROL_WMASK;
      rd_mux[`USS_B_OVERRUN_ERROR] = r_reg.overrun_error;
      rd_mux[`USS_B_RX_NINTH_BIT_VALUE] = r_reg.fifo[r_reg.fifo_rd][8];   // [R22]
    end else if (reg_hit(paddr, `USS_IDX_RXFIFO)) begin
      rd_mux = r_reg.fifo[r_reg.fifo_rd][7:0];
    end else if (reg_hit(paddr, `USS_IDX_IRQE)) begin
      rd_mux = r_reg.irqe;
    end else if (reg_hit(paddr, `USS_IDX_TRANSMIT_STATUS_CONTROL)) begin
      rd_mux = r_reg.transmit_status_control & `USS_TRANSMIT_STATUS_CONTROL_WMASK;
      rd_mux[`USS_B_SHIFT_EMPTY_FLAG] = (r_reg.tx_state == USS_TX_IDLE);
    end else if (reg_hit(paddr, `USS_IDX_BAUD)) begin
      rd_mux = r_reg.baud;
    end
  end

  // Next-state logic for registers, transmitter and receiver
  always_comb begin
    r_next    = r_reg;
    load      = 1'b0;
    word_done = 1'b0;
    push      = 1'b0;
    word      = 9'h000;

    // Read data is captured in the setup phase so prdata comes from a flop
    if (psel && !penable) begin
      r_next.prdata = {24'h000000, rd_mux};
      r_next.pop_ok = reg_hit(paddr, `USS_IDX_RXFIFO) & rxf;
    end
    // Only a FIFO that was non-empty at setup is popped, so no word is lost unseen
    pop = acc_rd & reg_hit(paddr, `USS_IDX_RXFIFO) & r_reg.pop_ok;   // [R22]

    // Register writes
    if (acc_wr) begin
      if (reg_hit(paddr, `USS_IDX_TRANSMIT_STATUS_CONTROL)) begin
        r_next.transmit_status_control = pwdata[7:0] & `USS_TRANSMIT_STATUS_CONTROL_WMASK;
      end
      if (reg_hit(paddr, `USS_IDX_RECEIVE_STATUS_CONTROL)) begin
        r_next.receive_status_control = pwdata[7:0] & `USS_RECEIVE_STATUS_CONTROL_WMASK;
      end
      if (reg_hit(paddr, `USS_IDX_IRQE)) begin
        r_next.irqe = pwdata[7:0];
      end
      if (reg_hit(paddr, `USS_IDX_BAUD)) begin
        r_next.baud = pwdata[7:0];
      end
    end

    // Transmitter; data changes after each falling edge the master samples on
    if (!tx_on) begin
      r_next.tx_state = USS_TX_IDLE;
      r_next.tx_cnt   = 4'h0;
    end else begin
      unique case (r_reg.tx_state)
        USS_TX_IDLE: begin
          load = r_reg.txbuf_full;                          // [R5]
        end
        USS_TX_SHIFT: begin
          if (clk_fall) begin                               // [R4]
            if (r_reg.tx_cnt == last_bit(r_reg.transmit_status_control[`USS_B_TX9])) begin
              r_next.tx_cnt   = 4'h0;
              r_next.tx_state = USS_TX_IDLE;
              load = r_reg.txbuf_full;                      // [R7]
            end else begin
              r_next.tx_cnt = r_reg.tx_cnt + 4'h1;
            end
          end
        end
      endcase
    end
    // Ninth bit is taken at transfer time, hence it must be loaded first
    if (load) begin
      r_next.tx_shift_register        = {r_reg.transmit_status_control[`USS_B_TX_NINTH_BIT_VALUE], r_reg.txbuf};  // [R15]
      r_next.txbuf_full = 1'b0;                                     // [R7]
      r_next.tx_state   = USS_TX_SHIFT;
      r_next.tx_cnt     = 4'h0;
    end
    // A write in the same cycle as a transfer wins, keeping the new word held
    if (acc_wr && reg_hit(paddr, `USS_IDX_TXBUF)) begin
      r_next.txbuf      = pwdata[7:0];
      r_next.txbuf_full = 1'b1;                                     // [R6]
    end
    r_next.dout = r_next.tx_shift_register[r_next.tx_cnt];
    r_next.doe  = (r_next.tx_state == USS_TX_SHIFT);

    // Receiver
    if (!rx_on) begin
      r_next.rx_cnt = 4'h0;
    end else if (clk_fall) begin                                    // [R19]
      r_next.rx_shift_register[r_reg.rx_cnt] = data_lvl;
      if (r_reg.rx_cnt == last_bit(r_reg.receive_status_control[`USS_B_RX9])) begin
        r_next.rx_cnt = 4'h0;
        word_done     = 1'b1;
      end else begin
        r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
      end
    end
    word    = r_next.rx_shift_register;
    word[8] = r_reg.receive_status_control[`USS_B_RX9] & r_next.rx_shift_register[8];              // [R22]
    if (word_done) begin
      if (r_reg.overrun_error) begin
        push = 1'b0;                                                // [R21]
      end else if (r_reg.fifo_cnt == `USS_FIFO_FULL) begin
        r_next.overrun_error = 1'b1;                                         // [R20]
      end else begin
        push = 1'b1;                                                // [R11]
      end
    end
    // Clearing continuous receive clears the error; it has no later set to race
    if (!r_reg.receive_status_control[`USS_B_CONTINUOUS_RECEIVE_ENABLE]) begin
      r_next.overrun_error = 1'b0;                                           // [R18]
    end

    // FIFO pointers
    if (push) begin
      r_next.fifo[r_reg.fifo_wr] = word;
      r_next.fifo_wr = ~r_reg.fifo_wr;
    end
    if (pop) begin
      r_next.fifo_rd = ~r_reg.fifo_rd;
    end
    r_next.fifo_cnt = r_reg.fifo_cnt + {1'b0, push} - {1'b0, pop};
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= ST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [1:0] fcnt_past;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_past <= 2'h0;
    end else begin
      fcnt_past <= r_reg.fifo_cnt;
    end
  end

  property p_idle_load;
    (r_reg.tx_state == USS_TX_IDLE) && r_reg.txbuf_full && tx_on && !acc_wr
      |=> (r_reg.tx_state == USS_TX_SHIFT) && !r_reg.txbuf_full ##1 serial_data_pin_oe;
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("idle shifter did not take buffer"); // [R5]

  property p_held_flag;
    r_reg.txbuf_full |-> !irqf_val[`USS_B_TXF];
  endproperty
  a_held_flag: assert property (p_held_flag) else $error("empty flag set with word held"); // [R6]

  property p_chain;
    tx_on && (r_reg.tx_state == USS_TX_SHIFT) && clk_fall && r_reg.txbuf_full && !acc_wr &&
      (r_reg.tx_cnt == last_bit(r_reg.transmit_status_control[`USS_B_TX9]))
      |=> (r_reg.tx_state == USS_TX_SHIFT) && (r_reg.tx_cnt == 4'h0) && txf;
  endproperty
  a_chain: assert property (p_chain) else $error("held word not moved after last bit"); // [R7]

  property p_irq;
    (txf && r_reg.irqe[`USS_B_TXF]) || (rxf && r_reg.irqe[`USS_B_RXF]) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag without interrupt"); // [R8]

  property p_no_irq;
    !r_reg.irqe[`USS_B_TXF] && !r_reg.irqe[`USS_B_RXF] |-> !irq;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt while disabled"); // [R13]

  property p_overrun;
    word_done && !r_reg.overrun_error && (r_reg.fifo_cnt == `USS_FIFO_FULL) && r_reg.receive_status_control[`USS_B_CONTINUOUS_RECEIVE_ENABLE]
      |=> r_reg.overrun_error && (r_reg.fifo_cnt <= fcnt_past);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged on full FIFO"); // [R20]

  property p_block;
    r_reg.overrun_error |=> (r_reg.fifo_cnt <= $past(r_reg.fifo_cnt));
  endproperty
  a_block: assert property (p_block) else $error("FIFO grew during overrun"); // [R21]

  property p_push;
    word_done && !r_reg.overrun_error && (r_reg.fifo_cnt != `USS_FIFO_FULL) |=> rxf;
  endproperty
  a_push: assert property (p_push) else $error("received word not in FIFO"); // [R11]

  property p_err_clr;
    !r_reg.receive_status_control[`USS_B_CONTINUOUS_RECEIVE_ENABLE] |=> !r_reg.overrun_error;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("overrun kept after receive disabled"); // [R18]

  property p_fall_only;
    rx_on && (r_reg.rx_cnt != r_next.rx_cnt) |-> clk_fall;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("receive shift without falling edge"); // [R19]

  c_tx_word: cover property ((r_reg.tx_state == USS_TX_SHIFT) ##1 (r_reg.tx_state == USS_TX_IDLE));
  c_rx_push: cover property (push ##1 rxf);
  c_overrun: cover property ($rose(r_reg.overrun_error));

endmodule : uss_sync_slave

`default_nettype wire

// File: uss_params.svh
// Register indices, field positions and reset values of the synchronous slave serial port
`ifndef USS_PARAMS_SVH
`define USS_PARAMS_SVH

`define USS_ADDR_W      10
`define USS_IDX_W       8
`define USS_IDX_IRQF    8'h0C
`define USS_IDX_RECEIVE_STATUS_CONTROL   8'h18
`define USS_IDX_TXBUF   8'h19
`define USS_IDX_RXFIFO  8'h1A
`define USS_IDX_IRQE    8'h8C
`define USS_IDX_TRANSMIT_STATUS_CONTROL   8'h98
`define USS_IDX_BAUD    8'h99

`define USS_B_CLOCK_SOURCE_SELECT      7
`define USS_B_TX9       6
`define USS_B_TRANSMIT_ENABLE      5
`define USS_B_SYNC      4
`define USS_B_SHIFT_EMPTY_FLAG      1
`define USS_B_TX_NINTH_BIT_VALUE      0
`define USS_B_SERIAL_PORT_ENABLE      7
`define USS_B_RX9       6
`define USS_B_CONTINUOUS_RECEIVE_ENABLE      4
`define USS_B_FRAMING_ERROR      2
`define USS_B_OVERRUN_ERROR      1
`define USS_B_RX_NINTH_BIT_VALUE      0
`define USS_B_RXF       5
`define USS_B_TXF       4

`define USS_TRANSMIT_STATUS_CONTROL_RST   8'h02
`define USS_TRANSMIT_STATUS_CONTROL_WMASK 8'hF5
`define USS_RECEIVE_STATUS_CONTROL_WMASK 8'hF8
`define USS_LAST8       4'h7
`define USS_LAST9       4'h8
`define USS_FIFO_FULL   2'h2

`endif

// File: uss_pkg.sv
// Types shared by the synchronous slave serial port modules
package uss_pkg;

  // Transmitter phase, one bit wide so every code is legal
  typedef enum logic [0:0] {
    USS_TX_IDLE  = 1'b0,
    USS_TX_SHIFT = 1'b1
  } uss_tx_state_t;

  // Synchroniser state
  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
    logic rise;
    logic fall;
  } uss_sync_t;

  // Complete state of the port
  typedef struct packed {
    logic [7:0]      transmit_status_control;
    logic [7:0]      receive_status_control;
    logic [7:0]      irqe;
    logic [7:0]      baud;
    logic [7:0]      txbuf;
    logic            txbuf_full;
    uss_tx_state_t   tx_state;
    logic [8:0]      tx_shift_register;
    logic [3:0]      tx_cnt;
    logic            dout;
    logic            doe;
    logic [8:0]      rx_shift_register;
    logic [3:0]      rx_cnt;
    logic            overrun_error;
    logic [1:0][8:0] fifo;
    logic            fifo_rd;
    logic            fifo_wr;
    logic [1:0]      fifo_cnt;
    logic [31:0]     prdata;
    logic            pop_ok;
  } uss_state_t;

endpackage : uss_pkg

// File: uss_edge_sync.sv
// Three-stage synchroniser with a stable level and one-cycle edge pulses
`timescale 1ns/1ps
`default_nettype none

module uss_edge_sync
  import uss_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  uss_sync_t s_reg;
  uss_sync_t s_next;

  // A change counts only once stages two and three agree; stage one feeds stage two alone
  always_comb begin
    s_next      = s_reg;
    s_next.ff1  = async_in;
    s_next.ff2  = s_reg.ff1;
    s_next.ff3  = s_reg.ff2;
    s_next.rise = 1'b0;
    s_next.fall = 1'b0;
    if ((s_reg.ff2 == s_reg.ff3) && (s_reg.ff3 != s_reg.level)) begin
      s_next.level = s_reg.ff3;
      s_next.rise  = s_reg.ff3;
      s_next.fall  = ~s_reg.ff3;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.level;
  assign rise  = s_reg.rise;
  assign fall  = s_reg.fall;

endmodule : uss_edge_sync

`default_nettype wire

// File: uss_master_model.sv
// Behavioural model of the external master that clocks the slave port
`timescale 1ns/1ps
`default_nettype none

module uss_master_model (
  output logic      shift_clock,
  output logic      data_level,
  input  wire logic dut_data,
  input  wire logic dut_oe
);
  logic drv_en;
  logic drv_val;
  logic last_level;

  initial begin
    shift_clock = 1'b0;
    drv_en      = 1'b0;
    drv_val     = 1'b0;
    last_level  = 1'b0;
  end

  // Remember what the wire carried while someone drove it
  always @(dut_oe, dut_data, drv_en, drv_val) begin
    if (dut_oe)
      last_level = dut_data;
    else if (drv_en)
      last_level = drv_val;
  end

  // No pull on the line: once released it shows the inverse, so stale bits never pass
  assign data_level = dut_oe ? dut_data : (drv_en ? drv_val : ~last_level);

  // One word, LSB first; clock idles low and stands still between words
  task automatic frame(input int nbits, input logic [8:0] tx, input logic drive, input int half,
                       output logic [8:0] rx);
    rx = 9'h000;
    #3;
    for (int i = 0; i < nbits; i++) begin
      shift_clock = 1'b1;
      drv_en      = drive;
      drv_val     = tx[i];
      #(half);
      shift_clock = 1'b0;
      rx[i]       = data_level;
      #(half);
    end
    drv_en = 1'b0;
  endtask : frame

endmodule : uss_master_model
`default_nettype wire

// File: uss_tb.sv
// Self-checking bench for the synchronous slave serial port
`timescale 1ns/1ps
`default_nettype none

`include "uss_params.svh"

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } uss_row_t;

  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [`USS_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  wire logic [31:0]       prdata;
  wire logic              pready;
  wire logic              pslverr;
  wire logic              irq;
  wire logic              sck;
  wire logic              din;
  wire logic              dout;
  wire logic              doe;
  int                     fail_count;
  int                     n_compared;
  logic [8:0]             q;
  logic [31:0]            v;
  logic                   e;

  // Reset values first, then write and read back
  uss_row_t rows [14] = '{
    '{1'b0, `USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h00, 8'h02}, '{1'b0, `USS_IDX_RECEIVE_STATUS_CONTROL, 8'h00, 8'h00},
    '{1'b0, `USS_IDX_IRQF, 8'h00, 8'h00}, '{1'b0, `USS_IDX_IRQE, 8'h00, 8'h00},
    '{1'b0, `USS_IDX_BAUD, 8'h00, 8'h00}, '{1'b0, `USS_IDX_RXFIFO, 8'h00, 8'h00},
    '{1'b0, `USS_IDX_TXBUF, 8'h00, 8'h00}, '{1'b1, `USS_IDX_BAUD, 8'hA5, 8'hA5},
    '{1'b1, `USS_IDX_IRQE, 8'h30, 8'h30}, '{1'b1, `USS_IDX_IRQE, 8'h00, 8'h00},
    '{1'b1, `USS_IDX_TRANSMIT_STATUS_CONTROL, 8'hFF, 8'hF7}, '{1'b1, `USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h00, 8'h02},
    '{1'b1, `USS_IDX_RECEIVE_STATUS_CONTROL, 8'hFF, 8'hF8}, '{1'b1, `USS_IDX_RECEIVE_STATUS_CONTROL, 8'h00, 8'h00}};

  uss_sync_slave dut (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .shift_clock_pin    (sck),
    .serial_data_pin_i  (din),
    .serial_data_pin_o  (dout),
    .serial_data_pin_oe (doe),
    .irq                (irq)
  );

  uss_master_model pm (
    .shift_clock (sck),
    .data_level  (din),
    .dut_data    (dout),
    .dut_oe      (doe)
  );

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count is assumed; only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        x;
    apb(1'b1, idx, d, r, x);
  endtask : wr

  // Masked read check; upper bits must always read zero
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] m);
    logic [31:0] r;
    logic        x;
    apb(1'b0, idx, 8'h00, r, x);
    `CHK(r & {24'hFFFFFF, m}, {24'h000000, exp & m})
    `CHK(x, 1'b0)
  endtask : rd_chk

  // Master sends one word, then the port gets time to store it
  task automatic rx_word(input logic [8:0] w, input int n);
    pm.frame(n, w, 1'b1, 40, q);
    repeat (8) @(posedge pclk);
  endtask : rx_word

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // Watchdog far beyond the expected run length
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h00000000;
    fail_count = 0;
    n_compared = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      if (rows[i].wr)
        wr(rows[i].idx, rows[i].wd);
      rd_chk(rows[i].idx, rows[i].exp, 8'hFF);
    end
    // Unmapped address is refused and reads zero
    apb(1'b0, 8'h01, 8'h00, v, e);
    `CHK(e, 1'b1)
    `CHK(v, 32'h00000000)
    // Two words back to back, second waits in the buffer
    wr(`USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h30);
    wr(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'h80);
    wr(`USS_IDX_IRQE, 8'h10);
    wr(`USS_IDX_TXBUF, 8'hA5);
    rd_chk(`USS_IDX_IRQF, 8'h10, 8'hFF);
    wr(`USS_IDX_TXBUF, 8'h3C);
    rd_chk(`USS_IDX_IRQF, 8'h00, 8'hFF);
    `CHK(irq, 1'b0)
    pm.frame(8, 9'h000, 1'b0, 40, q);
    `CHK(q[7:0], 8'hA5)
    repeat (8) @(posedge pclk);
    rd_chk(`USS_IDX_IRQF, 8'h10, 8'hFF);
    `CHK(irq, 1'b1)
    pm.frame(8, 9'h000, 1'b0, 40, q);
    `CHK(q[7:0], 8'h3C)
    repeat (8) @(posedge pclk);
    `CHK(doe, 1'b0)
    // Nine-bit word, ninth bit loaded before the data
    wr(`USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h71);
    wr(`USS_IDX_TXBUF, 8'h5A);
    pm.frame(9, 9'h000, 1'b0, 40, q);
    `CHK(q, 9'h15A)
    repeat (8) @(posedge pclk);
    wr(`USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h10);
    wr(`USS_IDX_IRQE, 8'h00);
    // Single receive enable alone receives nothing
    wr(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'hA0);
    rx_word(9'h0AA, 8);
    rd_chk(`USS_IDX_IRQF, 8'h00, 8'h20);
    // Clock source select set: not a slave, nothing shifts in
    wr(`USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h90);
    wr(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'hD0);
    rx_word(9'h0AA, 8);
    rd_chk(`USS_IDX_IRQF, 8'h00, 8'h20);
    wr(`USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h10);
    wr(`USS_IDX_IRQE, 8'h20);
    rx_word(9'h1C3, 9);
    rd_chk(`USS_IDX_IRQF, 8'h20, 8'h20);
    `CHK(irq, 1'b1)
    rd_chk(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'hD1, 8'hFF);
    rd_chk(`USS_IDX_RXFIFO, 8'hC3, 8'hFF);
    rd_chk(`USS_IDX_IRQF, 8'h00, 8'h20);
    `CHK(irq, 1'b0)
    // Three words into a two-deep FIFO
    rx_word(9'h011, 9);
    rx_word(9'h122, 9);
    rx_word(9'h033, 9);
    rd_chk(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'hD2, 8'hFF);
    rd_chk(`USS_IDX_RXFIFO, 8'h11, 8'hFF);
    rd_chk(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'hD3, 8'hFF);
    rd_chk(`USS_IDX_RXFIFO, 8'h22, 8'hFF);
    rx_word(9'h044, 9);
    rd_chk(`USS_IDX_IRQF, 8'h00, 8'h20);
    wr(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'hC0);
    rd_chk(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'hC0, 8'hFF);
    wr(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'hD0);
    rx_word(9'h155, 9);
    rd_chk(`USS_IDX_RXFIFO, 8'h55, 8'hFF);
    // Eight-bit word after a nine-bit one; the stale ninth bit must not show
    wr(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'h90);
    rx_word(9'h1E7, 8);
    rd_chk(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'h90, 8'hFF);
    rd_chk(`USS_IDX_RXFIFO, 8'hE7, 8'hFF);
    // Reset in mid-run with a word loaded and the interrupt up
    wr(`USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h30);
    wr(`USS_IDX_IRQE, 8'h30);
    wr(`USS_IDX_TXBUF, 8'h99);
    @(posedge pclk);
    #1;
    `CHK(doe, 1'b1)
    `CHK(irq, 1'b1)
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    `CHK(irq, 1'b0)
    `CHK(doe, 1'b0)
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h02, 8'hFF);
    rd_chk(`USS_IDX_IRQF, 8'h00, 8'hFF);
    rd_chk(`USS_IDX_RECEIVE_STATUS_CONTROL, 8'h00, 8'hFF);
    print_verdict();
  end

endmodule : tb
`default_nettype wire
